// ==== hdl/ctc_top.sv ====
// four channel counter timer: host port, channels, interrupt daisy chain
`timescale 1ns/10ps
module ctc_top
(
	input  wire logic       CLK,
	input  wire logic       RST_N,
	input  wire logic [7:0] D_IN,
	output logic      [7:0] D_OUT,
	output logic            D_OE,
	input  wire logic       CHIP_ENABLE_N,
	input  wire logic       CHAN_SEL_HI,
	input  wire logic       CHAN_SEL_LO,
	input  wire logic       IO_REQUEST_N,
	input  wire logic       FIRST_CYCLE_MARKER_N,
	input  wire logic       READ_N,
	input  wire logic       AUTO_WAIT_CYCLE,
	input  wire logic [3:0] EXT_CLOCK_TRIGGER,
	output logic      [2:0] ZERO_COUNT_PULSE,
	output logic            IRQ_N_OUT,
	output logic            IRQ_OE,
	input  wire logic       PRIORITY_IN,
	output logic            PRIORITY_OUT
);
	localparam int N = ctc_pkg::NUM_CHAN;

	// state of a channel
	typedef enum { CH_IDLE, CH_WAIT_SETUP, CH_WAIT_TRIG, CH_RUN } chan_e;

	ctc_pkg::bus_s bus;                 // bundled host strobes
	logic [1:0]    chan;                // addressed channel
	logic          wr_take;             // write latched this cycle
	logic          rd_sel;              // read cycle in progress
	logic          ack;                 // interrupt acknowledge
	logic          ack_q;               // acknowledge seen last cycle
	logic [7:0]    ctrl      [N];       // channel control registers
	logic [7:0]    tc        [N];       // reload constants
	logic [7:0]    cnt       [N];       // down counters
	logic [7:0]    pre       [N];       // prescalers
	logic          tc_expect [N];       // next byte is a constant
	logic          tc_valid  [N];       // constant received
	logic          tc_new    [N];       // constant waits for zero
	chan_e         st        [N];       // channel state
	logic [3:0]    setup_cnt [N];       // start delay counter
	logic [3:0]    trg_s1;              // trigger sync stage 1
	logic [3:0]    trg_s2;              // trigger sync stage 2
	logic [3:0]    trg_s3;              // previous synced level
	logic [3:0]    edge_act;            // active edge this cycle
	logic [3:0]    slope_chg;           // slope change acts as edge
	logic [3:0]    dec;                 // decrement this cycle
	logic [3:0]    zero_hit;            // counter reaches zero
	logic [3:0]    pend;                // pending interrupt requests
	logic [3:0]    serv;                // channels under service
	logic [4:0]    vec_hi;              // upper vector bits
	logic          prefix_seen;         // first return byte decoded
	logic [1:0]    pick;                // winning channel code
	logic          any_pend;            // some request pending
	logic [2:0]    zc;                  // zero pulse register

	// highest priority set bit of a 4-bit vector, channel 0 first
	function automatic logic [1:0] first_set(input logic [3:0] v);
		if (v[0])      return 2'h0;
		else if (v[1]) return 2'h1;
		else if (v[2]) return 2'h2;
		else           return 2'h3;
	endfunction

	// bundle the strobes; select pins are a binary channel number
	always_comb
	begin
		bus.io_request_n         = IO_REQUEST_N;
		bus.first_cycle_marker_n = FIRST_CYCLE_MARKER_N;
		bus.read_n               = READ_N;
		bus.chip_enable_n        = CHIP_ENABLE_N;
		bus.sel                  = {CHAN_SEL_HI, CHAN_SEL_LO};
	end

	assign chan = bus.sel;
	// write taken on the wait cycle edge, never during acknowledge
	assign wr_take = !bus.io_request_n && !bus.chip_enable_n && bus.read_n
		&& bus.first_cycle_marker_n && AUTO_WAIT_CYCLE;
	assign rd_sel = !bus.io_request_n && !bus.chip_enable_n && !bus.read_n
		&& bus.first_cycle_marker_n;
	assign ack = !bus.io_request_n && !bus.first_cycle_marker_n;

	// trigger resynchroniser; stage one feeds only stage two
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			trg_s1 <= 4'h0;
			trg_s2 <= 4'h0;
			trg_s3 <= 4'h0;
		end
		else
		begin
			trg_s1 <= EXT_CLOCK_TRIGGER;
			trg_s2 <= trg_s1;
			trg_s3 <= trg_s2;
		end
	end

	// per channel edge, slope change and decrement decode
	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			// rising or falling per control bit
			edge_act[i] = ctrl[i][ctc_pkg::BIT_RISE] ? (trg_s2[i] && !trg_s3[i])
				: (!trg_s2[i] && trg_s3[i]);
			// a control write flipping the slope counts as an edge
			slope_chg[i] = wr_take && chan == 2'(i) && D_IN[ctc_pkg::BIT_CTRL]
				&& !tc_expect[i] && !D_IN[ctc_pkg::BIT_SWRST]
				&& D_IN[ctc_pkg::BIT_RISE] != ctrl[i][ctc_pkg::BIT_RISE];
			if (st[i] != CH_RUN)
				dec[i] = 1'b0;
			else if (ctrl[i][ctc_pkg::BIT_COUNTER])
				dec[i] = edge_act[i] || slope_chg[i];
			else
				dec[i] = (pre[i] & (ctrl[i][ctc_pkg::BIT_DIV256] ? ctc_pkg::PRE_MASK256
					: ctc_pkg::PRE_MASK16)) == 8'h00;
			zero_hit[i] = dec[i] && cnt[i] == 8'h01;
		end
	end

	// control, constant and vector writes
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			vec_hi <= ctc_pkg::VEC_RESET[7:3];
			for (int i = 0; i < N; i++)
			begin
				ctrl[i]      <= ctc_pkg::CTRL_RESET;
				tc[i]        <= 8'h00;
				tc_expect[i] <= 1'b0;
			end
		end
		else if (wr_take)
		begin
			if (tc_expect[chan])
			begin
				tc[chan]        <= D_IN;
				tc_expect[chan] <= 1'b0;
			end
			else if (D_IN[ctc_pkg::BIT_CTRL])
			begin
				ctrl[chan]      <= D_IN;
				tc_expect[chan] <= D_IN[ctc_pkg::BIT_TC_NEXT];
			end
			else if (chan == 2'h0)
				vec_hi <= D_IN[7:3];
		end
	end

	// channel sequencing, prescaler and down counter
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			for (int i = 0; i < N; i++)
			begin
				st[i]        <= CH_IDLE;
				cnt[i]       <= 8'h00;
				pre[i]       <= 8'h00;
				tc_valid[i]  <= 1'b0;
				tc_new[i]    <= 1'b0;
				setup_cnt[i] <= 4'h0;
			end
		end
		else
		begin
			for (int i = 0; i < N; i++)
			begin
				if (wr_take && chan == 2'(i) && !tc_expect[i] && D_IN[ctc_pkg::BIT_CTRL]
					&& D_IN[ctc_pkg::BIT_SWRST])
				begin
					st[i]       <= CH_IDLE;
					tc_valid[i] <= 1'b0;
					tc_new[i]   <= 1'b0;
				end
				else if (wr_take && chan == 2'(i) && tc_expect[i] && st[i] != CH_RUN)
				begin
					tc_valid[i]  <= 1'b1;
					cnt[i]       <= D_IN;
					pre[i]       <= 8'h00;
					setup_cnt[i] <= 4'(ctc_pkg::SETUP_CYCLES);
					st[i]        <= CH_WAIT_SETUP;
				end
				else
				begin
					case (st[i])
						CH_IDLE: ; // no constant, no counting
						CH_WAIT_SETUP:
						begin
							if (setup_cnt[i] != 4'h0)
								setup_cnt[i] <= setup_cnt[i] - 4'h1;
							else if (ctrl[i][ctc_pkg::BIT_COUNTER])
								st[i] <= CH_RUN;
							else if (ctrl[i][ctc_pkg::BIT_EXT_TRIG])
								st[i] <= CH_WAIT_TRIG;
							else
								st[i] <= CH_RUN;
						end
						CH_WAIT_TRIG:
							if (edge_act[i] || slope_chg[i])
								st[i] <= CH_RUN;
						CH_RUN:
						begin
							if (!ctrl[i][ctc_pkg::BIT_COUNTER])
								pre[i] <= pre[i] + 8'h01;
							if (dec[i])
							begin
								if (zero_hit[i])
								begin
									cnt[i]    <= tc[i];
									tc_new[i] <= 1'b0;
								end
								else
									cnt[i] <= cnt[i] - 8'h01;
							end
						end
						default: st[i] <= CH_IDLE;
					endcase
					// a constant for a running channel must not stall the count
					if (wr_take && chan == 2'(i) && tc_expect[i])
						tc_new[i] <= 1'b1;
				end
			end
		end
	end

	// zero count pulses for channels 0 to 2
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			zc <= 3'h0;
		else
			zc <= zero_hit[2:0];
	end
	assign ZERO_COUNT_PULSE = zc;

	assign any_pend = |pend;
	assign pick     = first_set(pend);

	// interrupt pending and service state; requests frozen during acknowledge
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			pend        <= 4'h0;
			serv        <= 4'h0;
			prefix_seen <= 1'b0;
			ack_q       <= 1'b0;
		end
		else
		begin
			ack_q <= ack;
			for (int i = 0; i < N; i++)
			begin
				if (!ctrl[i][ctc_pkg::BIT_IRQ_EN])
					pend[i] <= 1'b0;
				else if (zero_hit[i] && bus.first_cycle_marker_n)
					pend[i] <= 1'b1;
				else if (ack && !ack_q && PRIORITY_IN && any_pend && pick == 2'(i))
				begin
					pend[i] <= 1'b0;
					serv[i] <= 1'b1;
				end
			end
			// return opcode pair releases the top serviced channel
			if (!bus.first_cycle_marker_n && bus.read_n == 1'b0 && bus.io_request_n)
			begin
				prefix_seen <= (D_IN == ctc_pkg::OP_PREFIX);
				if (prefix_seen && D_IN == ctc_pkg::OP_RETURN && PRIORITY_IN && serv != 4'h0)
					serv[first_set(serv)] <= 1'b0;
			end
		end
	end

	// daisy chain outputs: open drain request, priority pass through
	assign IRQ_N_OUT    = 1'b0;
	assign IRQ_OE       = RST_N && any_pend;
	assign PRIORITY_OUT = PRIORITY_IN && (serv == 4'h0 || !RST_N);

	// read data and vector drive registered
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			D_OUT <= 8'h00;
			D_OE  <= 1'b0;
		end
		else if (ack && PRIORITY_IN && any_pend)
		begin
			D_OUT <= {vec_hi, pick, 1'b0};
			D_OE  <= 1'b1;
		end
		else if (rd_sel)
		begin
			D_OUT <= cnt[chan];
			D_OE  <= 1'b1;
		end
		else if (!ack)
			D_OE <= 1'b0;
	end

	// auto timer is running by the third edge after the constant write
	auto_start_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(wr_take && chan == 2'h0 && tc_expect[0] && st[0] != CH_RUN
		&& !ctrl[0][ctc_pkg::BIT_COUNTER] && !ctrl[0][ctc_pkg::BIT_EXT_TRIG])
		|-> ##3 st[0] == CH_RUN)
		else $error("auto timer did not start");
	new_const_wait_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(tc_new[0] && dec[0] && !zero_hit[0] && !wr_take) |=> cnt[0] == $past(cnt[0]) - 8'h01)
		else $error("new constant cut the count short");
	zero_reload_a: assert property (@(posedge CLK) disable iff (!RST_N)
		zero_hit[1] |=> cnt[1] == $past(tc[1]))
		else $error("reload at zero missing");
	idle_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
		!tc_valid[2] |-> st[2] != CH_RUN)
		else $error("counting without constant");
	zc_pulse_a: assert property (@(posedge CLK) disable iff (!RST_N)
		zero_hit[0] |=> ZERO_COUNT_PULSE[0] ##1 (!ZERO_COUNT_PULSE[0] || $past(zero_hit[0])))
		else $error("zero pulse wrong");
	soft_reset_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(wr_take && chan == 2'h0 && !tc_expect[0] && D_IN[0] && D_IN[1])
		|=> st[0] == CH_IDLE && !tc_valid[0])
		else $error("soft reset did not stop");
	vec_form_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(ack && PRIORITY_IN && any_pend) |=> D_OE && D_OUT[0] == 1'b0
		&& D_OUT[2:1] == $past(pick) && D_OUT[7:3] == $past(vec_hi))
		else $error("vector malformed");
	irq_gate_a: assert property (@(posedge CLK) disable iff (!RST_N)
		!ctrl[3][ctc_pkg::BIT_IRQ_EN] |=> !pend[3])
		else $error("disabled channel requests");
	read_count_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(rd_sel && !ack) |=> D_OE && D_OUT == $past(cnt[chan]))
		else $error("read value wrong");
endmodule // ctc_top

// ==== hdl/ctc_pkg.sv ====
// package: constants, control word fields and carrier types for the four channel counter timer
//
// How it works
// - bit0 set byte is a control word
// - bit0 clear at channel 0 is vector
// - bit2 set: next byte is time constant
// - constant zero counts as 256
// - no counting before a time constant
// - running count finishes before new constant
// - select pins form binary channel number
// - hard reset stops all, outputs idle
// - bit1 soft reset stops, needs new constant
// - bits1 and 2 halt until constant
// - bit7 enables interrupt at zero count
// - bit6 mode, bit5 prescale 16 or 256
// - slope change acts as an active edge
// - auto timer starts after setup delay
// - timer reloads at zero, runs on
// - triggered timer starts after trigger edge
// - vector: five stored bits, channel code, zero
// - enabled writes accepted, reads return count
// - trigger edge decrements or starts timer
// - write taken on wait clock edge
// - acknowledge drives vector when priority high
// - channels 0 to 2 pulse at zero
// - return opcode pair releases serviced channel
package ctc_pkg;
	localparam int NUM_CHAN       = 4;        // channel count
	localparam int BIT_CTRL       = 0;        // control word marker
	localparam int BIT_SWRST      = 1;        // software reset
	localparam int BIT_TC_NEXT    = 2;        // time constant follows
	localparam int BIT_EXT_TRIG   = 3;        // external trigger
	localparam int BIT_RISE       = 4;        // rising active edge
	localparam int BIT_DIV256     = 5;        // prescale by 256
	localparam int BIT_COUNTER    = 6;        // counter mode
	localparam int BIT_IRQ_EN     = 7;        // interrupt enable
	localparam logic [7:0] CTRL_RESET = 8'h00; // control after reset
	localparam logic [7:0] VEC_RESET  = 8'h00; // vector after reset
	localparam logic [7:0] OP_PREFIX  = 8'hED; // return opcode first byte
	localparam logic [7:0] OP_RETURN  = 8'h4D; // return opcode second byte
	localparam logic [7:0] PRE_MASK16 = 8'h0F; // prescaler mask for 16
	localparam logic [7:0] PRE_MASK256 = 8'hFF; // prescaler mask for 256
	localparam int SETUP_CYCLES   = 1;        // setup delay after write

	// one host bus cycle's strobes
	typedef struct packed {
		logic       io_request_n;
		logic       first_cycle_marker_n;
		logic       read_n;
		logic       chip_enable_n;
		logic [1:0] sel;
	} bus_s;
endpackage : ctc_pkg

// ==== verif/host_bus_model.sv ====
// host processor model: write, read, acknowledge and opcode fetch cycles
`timescale 1ns/10ps
module host_bus_model
(
	input  wire logic       clk,
	input  wire logic [7:0] d_out,
	input  wire logic       d_oe,
	output logic      [7:0] d_in,
	output ctc_pkg::bus_s   bus,
	output logic            wait_edge
);
	// idle bus: every strobe inactive
	initial
	begin
		bus = 6'h3C;
		d_in = 8'h00;
		wait_edge = 1'b0;
	end

	// one bus cycle: fixed cycles last one clock, others wait for the answer
	task automatic cycle(input logic [5:0] s, input logic [7:0] d, input logic fixed,
		input logic we, output logic [7:0] q);
		int n;
		n = 0;
		q = 8'h00;
		@(posedge clk);
		#1;
		bus = s;
		d_in = d;
		wait_edge = we;
		if (fixed)
			@(posedge clk);
		else
		begin
			while (d_oe !== 1'b1 && n < 20)
			begin
				@(posedge clk);
				#1;
				n++;
			end
			q = d_out;
			@(posedge clk);
		end
		#1;
		bus = {4'hF, s[1:0]};
		// released data lines show the inverse, never a stale byte
		d_in = ~d;
		wait_edge = 1'b0;
	endtask

	// write taken at the wait-cycle edge
	task automatic wr(input logic [1:0] sel, input logic [7:0] d);
		logic [7:0] q;
		cycle({4'b0110, sel}, d, 1'b1, 1'b1, q);
	endtask

	task automatic rd(input logic [1:0] sel, output logic [7:0] q);
		cycle({4'b0100, sel}, 8'h00, 1'b0, 1'b0, q);
	endtask

	task automatic ack(output logic [7:0] q);
		cycle(6'h0C, 8'h00, 1'b0, 1'b0, q);
	endtask

	// opcode fetch byte seen by the return decoder
	task automatic op(input logic [7:0] d);
		logic [7:0] q;
		cycle(6'h24, d, 1'b1, 1'b0, q);
	endtask
endmodule // host_bus_model

// ==== verif/four_channel_counter_timer_bench.sv ====
// self-checking bench for the four channel counter timer
`timescale 1ns/10ps
module four_channel_counter_timer_bench;
	logic          clk = 1'b0;      // system clock
	logic          rst_n = 1'b0;    // synchronous reset
	logic    [3:0] trg = 4'h0;      // external triggers
	logic          pri_in = 1'b0;   // daisy chain in
	logic    [7:0] d_in;            // host to block
	logic    [7:0] d_out;           // block to host
	logic          d_oe;            // block drives data
	logic          wa;              // wait-cycle edge marker
	logic    [2:0] zcp;             // zero count pulses
	logic          irq_oe;          // request pulled low
	logic          irq_n;           // request level while pulled
	logic          pri_out;         // daisy chain out
	logic    [7:0] q;               // read result
	ctc_pkg::bus_s bus;             // host strobes
	int            n_errors = 0;
	int            samples_checked = 0;
	int            n;
	int            hits = 0;        // channel 1 pulse tally

	always #2 clk = ~clk;
	always @(posedge clk) if (zcp[1] === 1'b1) hits++;

	host_bus_model host (.clk(clk), .d_out(d_out), .d_oe(d_oe), .d_in(d_in), .bus(bus),
		.wait_edge(wa));
	ctc_top uut (.CLK(clk), .RST_N(rst_n), .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe),
		.CHIP_ENABLE_N(bus.chip_enable_n), .CHAN_SEL_HI(bus.sel[1]),
		.CHAN_SEL_LO(bus.sel[0]), .IO_REQUEST_N(bus.io_request_n),
		.FIRST_CYCLE_MARKER_N(bus.first_cycle_marker_n), .READ_N(bus.read_n),
		.AUTO_WAIT_CYCLE(wa), .EXT_CLOCK_TRIGGER(trg), .ZERO_COUNT_PULSE(zcp),
		.IRQ_N_OUT(irq_n), .IRQ_OE(irq_oe), .PRIORITY_IN(pri_in), .PRIORITY_OUT(pri_out));

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic report_and_stop;
		if (n_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// cycles until the next zero pulse, bounded
	task automatic gap(input int ch, output int c);
		c = 0;
		while (zcp[ch] !== 1'b1 && c < 600)
		begin
			@(posedge clk);
			#1;
			c++;
		end
	endtask

	// one full trigger pulse, long enough to clear the synchroniser
	task automatic edge_on(input int ch);
		trg[ch] = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		trg[ch] = 1'b0;
		repeat (8) @(posedge clk);
		#1;
	endtask

	// auto timer by 16: period, reload of a new constant, soft halt
	task automatic t_timer;
		host.wr(2'h0, 8'h05);
		host.wr(2'h0, 8'h02);
		gap(0, n);
		@(posedge clk);
		#1;
		gap(0, n);
		chk("timer period", 8'h20, 8'(n + 1));
		host.wr(2'h0, 8'h05);
		host.wr(2'h0, 8'h04);
		gap(0, n);
		@(posedge clk);
		#1;
		gap(0, n);
		chk("reloaded period", 8'h40, 8'(n + 1));
		host.wr(2'h0, 8'h07);
		repeat (4) @(posedge clk);
		n = 0;
		repeat (100) @(posedge clk) if (zcp[0] === 1'b1) n++;
		chk("pulses while halted", 8'h00, 8'(n));
		host.wr(2'h0, 8'h01);
		gap(0, n);
		chk("resumed", 8'h01, {7'h00, zcp[0]});
	endtask

	// counter mode: edges, non-disturbing reads, slope change, 256
	task automatic t_count;
		host.wr(2'h1, 8'h55);
		host.wr(2'h1, 8'h03);
		edge_on(1);
		host.rd(2'h1, q);
		chk("count after edge", 8'h02, q);
		host.rd(2'h1, q);
		chk("count reread", 8'h02, q);
		host.wr(2'h1, 8'h41);
		repeat (4) @(posedge clk);
		host.rd(2'h1, q);
		chk("count after slope change", 8'h01, q);
		n = hits;
		edge_on(1);
		chk("channel 1 zero pulse", 8'h01, 8'(hits - n));
		host.wr(2'h2, 8'h55);
		host.wr(2'h2, 8'h00);
		edge_on(2);
		host.rd(2'h2, q);
		chk("count from 256", 8'hFF, q);
	endtask

	// channel 3 interrupt, acknowledge vector, return release
	task automatic t_irq;
		host.wr(2'h0, 8'hA8);
		host.wr(2'h3, 8'hD5);
		host.wr(2'h3, 8'h01);
		edge_on(3);
		chk("request", 8'h01, {7'h00, irq_oe});
		chk("request level", 8'h00, {7'h00, irq_n});
		host.ack(q);
		chk("vector", 8'hAE, q);
		chk("priority blocked", 8'h00, {7'h00, pri_out});
		host.op(ctc_pkg::OP_PREFIX);
		host.op(ctc_pkg::OP_RETURN);
		@(posedge clk);
		#1;
		chk("priority restored", 8'h01, {7'h00, pri_out});
	endtask

	// triggered timer by 256: holds until its edge, then a 512-cycle period
	task automatic t_trig;
		host.wr(2'h2, 8'h3F);
		host.wr(2'h2, 8'h02);
		repeat (40) @(posedge clk);
		#1;
		host.rd(2'h2, q);
		chk("triggered timer waits", 8'h02, q);
		edge_on(2);
		host.rd(2'h2, q);
		chk("triggered timer started", 8'h01, q);
		gap(2, n);
		@(posedge clk);
		#1;
		gap(2, n);
		chk("by 256 period low byte", 8'h00, 8'(n + 1));
		chk("by 256 period high byte", 8'h02, 8'((n + 1) >> 8));
	endtask

	// hardware reset in mid-run: outputs idle, running channels stay stopped
	task automatic t_reset;
		rst_n = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("mid-run reset outputs", 8'h01, {3'h0, d_oe, zcp, pri_out});
		chk("mid-run reset request", 8'h00, {7'h00, irq_oe});
		rst_n = 1'b1;
		n = 0;
		repeat (300) @(posedge clk) if (zcp !== 3'h0) n++;
		chk("pulses after reset", 8'h00, 8'(n));
	endtask

	initial
	begin
		repeat (5) @(posedge clk);
		#1;
		chk("priority follows low", 8'h00, {7'h00, pri_out});
		pri_in = 1'b1;
		repeat (5) @(posedge clk);
		#1;
		chk("reset outputs", 8'h01, {3'h0, d_oe, zcp, pri_out});
		chk("reset request", 8'h00, {7'h00, irq_oe});
		rst_n = 1'b1;
		// every channel programmed afresh after reset
		t_timer;
		t_count;
		t_irq;
		t_trig;
		t_reset;
		report_and_stop;
	end

	// watchdog well past the few thousand cycles the tests need
	initial
	begin
		#100000;
		n_errors++;
		report_and_stop;
	end
endmodule // four_channel_counter_timer_bench
